//--- rtl/rco_pkg.sv
/*
  Shared constants for the reference clock output select block: register
  word indices, field positions, reset values and oscillator increments.
  Assumes a 125 MHz system clock that serves as the master clock.
*/
package rco_pkg;
	// Master clock rate in hertz.
	localparam logic [63:0] CLK_HZ = 64'h7735940;
	// Output rates in hertz.
	localparam logic [63:0] HZ_8K = 64'h1F40;
	localparam logic [63:0] HZ_64K = 64'hFA00;
	localparam logic [63:0] HZ_T1_FREE = 64'h608;
	localparam logic [63:0] HZ_E1_FREE = 64'h800;
	localparam logic [63:0] HZ_2M048 = 64'h1F4000;
	localparam logic [63:0] HZ_4M096 = 64'h3E8000;
	localparam logic [63:0] HZ_8M192 = 64'h7D0000;
	localparam logic [63:0] HZ_19M44 = 64'h128A180;
	localparam logic [63:0] HZ_32M768 = 64'h1F40000;

	// Phase increment of a 32-bit accumulator for a given rate.
	function automatic logic [31:0] inc_of(input logic [63:0] hz);
		logic [63:0] t;
		t = (hz << 32) / CLK_HZ;
		return t[31:0];
	endfunction

	// Increments of the three fixed oscillators: 8 kHz, T1 free, E1 free.
	localparam logic [31:0] FIX_INC [3] = '{inc_of(HZ_8K),
		inc_of(HZ_T1_FREE), inc_of(HZ_E1_FREE)};

	// Register word indices.
	localparam logic [2:0] IDX_FREE_CTRL = 3'h0;
	localparam logic [2:0] IDX_PRI_SEL = 3'h1;
	localparam logic [2:0] IDX_SEC_SEL = 3'h2;
	localparam logic [2:0] IDX_REF_CFG = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;

	// Free-running output control fields.
	localparam int T1_SEL_BIT = 0;
	localparam int T1_EN_BIT = 1;
	localparam int E1_SEL_BIT = 2;
	localparam int E1_EN_BIT = 3;
	// Source select fields.
	localparam int SRC_LSB = 0;
	localparam int RATE_BIT = 5;
	localparam int REF_EN_BIT = 6;
	localparam logic [4:0] SRC_EXT_FIRST = 5'h1D;
	localparam logic [4:0] SRC_CHANNELS = 5'h10;
	// Reference configuration fields.
	localparam int FREQ_LSB = 0;
	localparam int FREE_BIT = 3;
	localparam int SYNTH_BIT = 4;
	localparam int TAP_BIT = 6;
	// Status fields.
	localparam int ST_STRAP_LSB = 0;
	localparam int ST_PRI_E1_BIT = 4;
	localparam int ST_SEC_E1_BIT = 5;

	// Reset values; the synthesizer starts bypassed.
	localparam logic [7:0] RST_FREE_CTRL = 8'h00;
	localparam logic [7:0] RST_SEL = 8'h00;
	localparam logic [7:0] RST_REF_CFG = 8'h10;
endpackage

//--- rtl/rco_reference_clock_output_select.sv
/*
  Reference clock output select: two free-running outputs, two receive
  reference outputs with source selection, and a frequency synthesizer on
  the primary reference, configured over an Avalon-MM slave.
  Assumes all recovered, external and strap inputs are synchronous to
  sys_clk_in, which is the master clock, and that pads resolve the
  output enables.
*/
// Function
// - All clocks derive from master clock; straps captured.
// - T1 free output: enable, 8 kHz or T1.
// - E1 free output: enable, 8 kHz or E1.
// - Reference enable bit 6; disabled means high impedance.
// - Source field bits 4..0 pick channel clock.
// - Bypassed output follows channel T1/E1 rate.
// - Config bit 6 taps before or after attenuator.
// - Primary synthesizer bypassed by default, bit 4.
// - Frequency field bits 2..0 picks synthesizer rate.
// - Free-run bit 3 locks synthesizer to master.
// - Source codes 11101..11111 select external input.
// - External mode reproduces the external input clock when bypassed.
`timescale 1ns/1ps
module rco_reference_clock_output_select (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Avalon-MM slave, word addressed.
	input wire logic [2:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Straps and clock sources.
	input wire logic [3:0] master_multiplier_straps_in,
	input wire logic [15:0] recovered_clk_pre_ja_in,
	input wire logic [15:0] recovered_clk_post_ja_in,
	input wire logic [15:0] channel_e1_mode_in,
	input wire logic primary_external_clock_in,
	input wire logic secondary_external_clock_in,
	// Free-running outputs with enables.
	output logic t1_rate_free_output_out,
	output logic t1_rate_free_output_oe_out,
	output logic e1_rate_free_output_out,
	output logic e1_rate_free_output_oe_out,
	// Reference outputs with enables.
	output logic primary_reference_output_out,
	output logic primary_reference_output_oe_out,
	output logic secondary_reference_output_out,
	output logic secondary_reference_output_oe_out
);

	// Level of the source picked by a select field.
	function automatic logic src_level(input logic [4:0] f,
		input logic [15:0] ch, input logic ext);
		logic v;
		v = 1'b0;
		if (f >= rco_pkg::SRC_EXT_FIRST)
			v = ext;
		else if (f < rco_pkg::SRC_CHANNELS)
			v = ch[f[3:0]];
		return v;
	endfunction

	// Line mode (1 for E1) of the source picked by a select field.
	function automatic logic src_e1(input logic [4:0] f,
		input logic [15:0] e1, input logic rate);
		logic v;
		v = 1'b0;
		if (f >= rco_pkg::SRC_EXT_FIRST)
			v = rate;
		else if (f < rco_pkg::SRC_CHANNELS)
			v = e1[f[3:0]];
		return v;
	endfunction

	// Synthesizer increment for a frequency code; code 7 holds still.
	function automatic logic [31:0] synth_inc(input logic [2:0] c);
		logic [31:0] v;
		unique case (c)
			3'h0: v = rco_pkg::inc_of(rco_pkg::HZ_8K);
			3'h1: v = rco_pkg::inc_of(rco_pkg::HZ_64K);
			3'h2: v = rco_pkg::inc_of(rco_pkg::HZ_2M048);
			3'h3: v = rco_pkg::inc_of(rco_pkg::HZ_4M096);
			3'h4: v = rco_pkg::inc_of(rco_pkg::HZ_8M192);
			3'h5: v = rco_pkg::inc_of(rco_pkg::HZ_19M44);
			3'h6: v = rco_pkg::inc_of(rco_pkg::HZ_32M768);
			3'h7: v = 32'h0;
		endcase
		return v;
	endfunction

	// Software registers and bus state.
	logic [7:0] free_running_clock_output_ctrl;
	logic [7:0] primary_reference_source_select;
	logic [7:0] secondary_reference_source_select;
	logic [7:0] reference_clock_config;
	logic [7:0] next_free_ctrl, next_pri_sel, next_sec_sel, next_cfg;
	logic ack, next_ack; // Second cycle of a bus access.
	logic [31:0] next_rdata;
	logic [3:0] straps, next_straps; // Captured multiplier straps.
	logic strap_taken, next_strap_taken;
	logic [7:0] status_byte; // Read-only state view.

	// Decoded control fields.
	logic [4:0] pri_field, sec_field;
	logic pri_en, sec_en, synth_on, free_run;
	logic [15:0] tap_clk;
	logic pri_src, sec_src;

	assign pri_field = primary_reference_source_select[4:0];
	assign sec_field = secondary_reference_source_select[4:0];
	assign pri_en = primary_reference_source_select[rco_pkg::REF_EN_BIT];
	assign sec_en = secondary_reference_source_select[rco_pkg::REF_EN_BIT];
	// The synthesizer runs while its control bit is low.
	assign synth_on = ~reference_clock_config[rco_pkg::SYNTH_BIT];
	assign free_run = reference_clock_config[rco_pkg::FREE_BIT];
	// A high tap bit takes the clock ahead of the attenuator.
	assign tap_clk = reference_clock_config[rco_pkg::TAP_BIT] ?
		recovered_clk_pre_ja_in : recovered_clk_post_ja_in;
	assign pri_src = src_level(pri_field, tap_clk,
		primary_external_clock_in);
	assign sec_src = src_level(sec_field, tap_clk,
		secondary_external_clock_in);

	// Status shows straps and the line mode of each selected source.
	always_comb
	begin
		status_byte = 8'h00;
		status_byte[rco_pkg::ST_STRAP_LSB +: 4] = straps;
		status_byte[rco_pkg::ST_PRI_E1_BIT] = src_e1(pri_field,
			channel_e1_mode_in,
			primary_reference_source_select[rco_pkg::RATE_BIT]);
		status_byte[rco_pkg::ST_SEC_E1_BIT] = src_e1(sec_field,
			channel_e1_mode_in,
			secondary_reference_source_select[rco_pkg::RATE_BIT]);
	end

	// Wait one cycle, then complete; writes land on the completing edge.
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;

	// Next values of the bus, register and strap state.
	always_comb
	begin
		next_ack = (avs_read_in | avs_write_in) & ~ack;
		next_rdata = avs_readdata_out;
		next_free_ctrl = free_running_clock_output_ctrl;
		next_pri_sel = primary_reference_source_select;
		next_sec_sel = secondary_reference_source_select;
		next_cfg = reference_clock_config;
		// Straps are caught once, on the first edge after reset release.
		next_strap_taken = 1'b1;
		next_straps = strap_taken ? straps : master_multiplier_straps_in;
		// Read data is fetched in the waiting cycle; unmapped reads zero.
		if (avs_read_in & ~ack)
		begin
			unique case (avs_address_in)
				rco_pkg::IDX_FREE_CTRL:
					next_rdata = {24'h0, free_running_clock_output_ctrl};
				rco_pkg::IDX_PRI_SEL:
					next_rdata = {24'h0, primary_reference_source_select};
				rco_pkg::IDX_SEC_SEL:
					next_rdata = {24'h0, secondary_reference_source_select};
				rco_pkg::IDX_REF_CFG:
					next_rdata = {24'h0, reference_clock_config};
				rco_pkg::IDX_STATUS:
					next_rdata = {24'h0, status_byte};
				default:
					next_rdata = 32'h0;
			endcase
		end
		// Writes use byte lane 0; unmapped and read-only writes are dropped.
		if (avs_write_in & ack & avs_byteenable_in[0])
		begin
			unique case (avs_address_in)
				rco_pkg::IDX_FREE_CTRL:
					next_free_ctrl = avs_writedata_in[7:0];
				rco_pkg::IDX_PRI_SEL:
					next_pri_sel = avs_writedata_in[7:0];
				rco_pkg::IDX_SEC_SEL:
					next_sec_sel = avs_writedata_in[7:0];
				rco_pkg::IDX_REF_CFG:
					next_cfg = avs_writedata_in[7:0];
				default:
					next_cfg = reference_clock_config;
			endcase
		end
	end

	// Registers the bus, register and strap state.
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_b_in)
		begin
			ack <= 1'b0;
			avs_readdata_out <= 32'h0;
			free_running_clock_output_ctrl <= rco_pkg::RST_FREE_CTRL;
			primary_reference_source_select <= rco_pkg::RST_SEL;
			secondary_reference_source_select <= rco_pkg::RST_SEL;
			reference_clock_config <= rco_pkg::RST_REF_CFG;
			straps <= 4'h0;
			strap_taken <= 1'b0;
		end
		else
		begin
			ack <= next_ack;
			avs_readdata_out <= next_rdata;
			free_running_clock_output_ctrl <= next_free_ctrl;
			primary_reference_source_select <= next_pri_sel;
			secondary_reference_source_select <= next_sec_sel;
			reference_clock_config <= next_cfg;
			straps <= next_straps;
			strap_taken <= next_strap_taken;
		end
	end

	// Fixed oscillators on the master clock: 8 kHz, T1 free, E1 free.
	logic [31:0] acc [3];
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_fixed
			logic [31:0] next_acc;
			// Advances the phase by the rate's increment.
			always_comb
			begin
				next_acc = acc[g] + rco_pkg::FIX_INC[g];
			end
			// Registers the phase.
			always_ff @(posedge sys_clk_in)
			begin
				if (!rst_b_in)
					acc[g] <= 32'h0;
				else
					acc[g] <= next_acc;
			end
		end
	endgenerate

	// Synthesizer phase and source edge history.
	logic [31:0] syn, next_syn;
	logic [31:0] inc_now;
	logic src_q, next_src_q;
	assign inc_now = synth_inc(reference_clock_config[2:0]);

	// Free-run advances freely; otherwise each source rise realigns phase.
	always_comb
	begin
		next_src_q = pri_src;
		if (!free_run && pri_src && !src_q)
			next_syn = 32'h0;
		else
			next_syn = syn + inc_now;
	end

	// Registers the synthesizer phase.
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_b_in)
		begin
			syn <= 32'h0;
			src_q <= 1'b0;
		end
		else
		begin
			syn <= next_syn;
			src_q <= next_src_q;
		end
	end

	// Output levels and enables.
	logic next_t1, next_t1_oe, next_e1, next_e1_oe;
	logic next_pri, next_pri_oe, next_sec, next_sec_oe;
	logic [7:0] fc;
	assign fc = free_running_clock_output_ctrl;

	// Builds every output from its control bits; disabled outputs float.
	always_comb
	begin
		next_t1_oe = fc[rco_pkg::T1_EN_BIT];
		next_t1 = next_t1_oe &
			(fc[rco_pkg::T1_SEL_BIT] ? acc[1][31] : acc[0][31]);
		next_e1_oe = fc[rco_pkg::E1_EN_BIT];
		next_e1 = next_e1_oe &
			(fc[rco_pkg::E1_SEL_BIT] ? acc[2][31] : acc[0][31]);
		next_pri_oe = pri_en;
		if (synth_on)
			next_pri = pri_en & syn[31];
		else
			next_pri = pri_en & pri_src;
		next_sec_oe = sec_en;
		next_sec = sec_en & sec_src;
	end

	// Registers the outputs.
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_b_in)
		begin
			t1_rate_free_output_out <= 1'b0;
			t1_rate_free_output_oe_out <= 1'b0;
			e1_rate_free_output_out <= 1'b0;
			e1_rate_free_output_oe_out <= 1'b0;
			primary_reference_output_out <= 1'b0;
			primary_reference_output_oe_out <= 1'b0;
			secondary_reference_output_out <= 1'b0;
			secondary_reference_output_oe_out <= 1'b0;
		end
		else
		begin
			t1_rate_free_output_out <= next_t1;
			t1_rate_free_output_oe_out <= next_t1_oe;
			e1_rate_free_output_out <= next_e1;
			e1_rate_free_output_oe_out <= next_e1_oe;
			primary_reference_output_out <= next_pri;
			primary_reference_output_oe_out <= next_pri_oe;
			secondary_reference_output_out <= next_sec;
			secondary_reference_output_oe_out <= next_sec_oe;
		end
	end

	// Straps stay fixed after the first capture.
	strap_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		strap_taken && $past(strap_taken) |-> $stable(straps))
		else $error("Captured straps changed.");

	// T1 output floats while disabled and follows the selected rate.
	t1_output_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		##1 t1_rate_free_output_oe_out == $past(fc[1]) &&
		t1_rate_free_output_out == ($past(fc[1]) &&
		($past(fc[0]) ? $past(acc[1][31]) : $past(acc[0][31]))))
		else $error("T1 free output wrong.");

	// E1 output floats and stays low while disabled.
	e1_output_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		!fc[3] |=> !e1_rate_free_output_oe_out && !e1_rate_free_output_out)
		else $error("Disabled E1 output driven.");

	// Neither reference output drives while both are disabled.
	ref_disable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		!pri_en ##0 !sec_en |=> !primary_reference_output_oe_out &&
		!secondary_reference_output_oe_out)
		else $error("Disabled reference driven.");

	// Channel select passes the tapped channel clock when bypassed.
	channel_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		sec_en && sec_field < 5'h10 |=>
		secondary_reference_output_out == $past(tap_clk[sec_field[3:0]]))
		else $error("Secondary channel clock not passed.");

	// A high tap bit passes the pre attenuator clocks.
	tap_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		sec_en && sec_field < 5'h10 && reference_clock_config[6] |=>
		secondary_reference_output_out ==
		$past(recovered_clk_pre_ja_in[sec_field[3:0]]))
		else $error("Attenuator tap ignored.");

	// The synthesizer comes out of reset bypassed.
	synth_default_a: assert property (@(posedge sys_clk_in)
		$rose(rst_b_in) |-> !synth_on)
		else $error("Synthesizer not bypassed at reset.");

	// At the fastest code the synthesized output never holds one level
	// over three samples running, since each half period is under two.
	synth_toggle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(pri_en && synth_on && free_run &&
		reference_clock_config[2:0] == 3'h6)[*8] |->
		$changed(primary_reference_output_out) ||
		$past(primary_reference_output_out, 1) !=
		$past(primary_reference_output_out, 2))
		else $error("Synthesizer stalled.");

	// In free run the phase always advances by the code's increment.
	free_run_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		synth_on && free_run |=> syn == $past(syn) + $past(inc_now))
		else $error("Free-run phase not advancing.");

	// External codes reproduce the external input when bypassed.
	external_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		pri_en && !synth_on && pri_field >= 5'h1D |=>
		primary_reference_output_out == $past(primary_external_clock_in))
		else $error("External clock not reproduced.");

	// A bus access completes on the cycle after it starts.
	bus_answer_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(avs_read_in || avs_write_in) && !ack |=>
		ack && !avs_waitrequest_out)
		else $error("Bus answer late.");
endmodule

//--- verif/rco_line_partner_model.sv
/*
  Behavioural model of the line side: recovered channel clocks ahead of
  and behind the attenuator, per-channel line modes and the two external
  reference clocks.
  Assumes it shares sys_clk_in with the block, as all sources are synchronous.
*/
`timescale 1ns/1ps
module rco_line_partner_model #(
	// Per-channel line mode pattern, 1 means E1.
	parameter logic [15:0] E1_MAP = 16'hA5C3
) (
	// Master clock.
	input wire logic sys_clk_in,
	// Clock sources towards the block.
	output logic [15:0] recovered_clk_pre_ja_out,
	output logic [15:0] recovered_clk_post_ja_out,
	output logic [15:0] channel_e1_mode_out,
	output logic primary_external_clock_out,
	output logic secondary_external_clock_out
);
	// Shift register whose bits toggle often, so every channel is busy.
	logic [15:0] lfsr = 16'hACE1;

	// All line clocks advance on the master clock edge.
	always @(posedge sys_clk_in)
	begin
		lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end

	// The post tap differs from the pre tap so a wrong tap is seen.
	assign recovered_clk_pre_ja_out = lfsr;
	assign recovered_clk_post_ja_out = ~{lfsr[7:0], lfsr[15:8]};
	// Each channel keeps a fixed line mode.
	assign channel_e1_mode_out = E1_MAP;
	// External clocks differ from every channel pattern.
	assign primary_external_clock_out = lfsr[0] ^ lfsr[5];
	assign secondary_external_clock_out = lfsr[2] ^ lfsr[11];
endmodule

//--- verif/tb.sv
/*
  Self-checking bench: register access, source selection, synthesizer
  rates and free-running outputs, all through the Avalon-MM slave.
  Assumes the line model drives every clock source from sys_clk_in.
*/
`timescale 1ns/1ps
module tb;
	// Clock, reset and bus.
	logic sys_clk_in, rst_b_in, avs_read_in, avs_write_in;
	logic avs_waitrequest_out;
	logic [2:0] avs_address_in;
	logic [3:0] avs_byteenable_in, master_multiplier_straps_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	// Sources and outputs.
	logic [15:0] pre_ja, post_ja, e1_mode;
	logic ext_a, ext_b, t1_o, t1_oe, e1_o, e1_oe;
	logic pri_o, pri_oe, sec_o, sec_oe;
	int n_mismatch, n_checks;
	logic [31:0] q_drop; // Read data of a write access, never compared.
	// Synthesizer rates by frequency code, codes 0 and 3 unused in free run.
	longint rate [7] = '{8000, 64000, 2048000, 4096000, 8192000,
		19440000, 32768000};

	rco_reference_clock_output_select i_rco_reference_clock_output_select (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.master_multiplier_straps_in(master_multiplier_straps_in),
		.recovered_clk_pre_ja_in(pre_ja), .recovered_clk_post_ja_in(post_ja),
		.channel_e1_mode_in(e1_mode), .primary_external_clock_in(ext_a),
		.secondary_external_clock_in(ext_b),
		.t1_rate_free_output_out(t1_o), .t1_rate_free_output_oe_out(t1_oe),
		.e1_rate_free_output_out(e1_o), .e1_rate_free_output_oe_out(e1_oe),
		.primary_reference_output_out(pri_o),
		.primary_reference_output_oe_out(pri_oe),
		.secondary_reference_output_out(sec_o),
		.secondary_reference_output_oe_out(sec_oe));

	rco_line_partner_model i_rco_line_partner_model (
		.sys_clk_in(sys_clk_in), .recovered_clk_pre_ja_out(pre_ja),
		.recovered_clk_post_ja_out(post_ja), .channel_e1_mode_out(e1_mode),
		.primary_external_clock_out(ext_a),
		.secondary_external_clock_out(ext_b));

	// 125 MHz master clock.
	initial
	begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A wait that used up its bound counts as a mismatch and ends the run.
	task automatic timeout_stop;
		n_mismatch++;
		report_and_stop();
	endtask

	// Exact comparison of a value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Range comparison of a measured count.
	task automatic rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi)
		begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, lo);
		end
	endtask

	// One bus access, entered just after a rising edge; the request
	// holds until a rising edge samples waitrequest low, read data is
	// taken at that edge, and one idle edge follows the release.
	task automatic bus(input logic wr, input logic [2:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		int n;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (avs_waitrequest_out !== 1'b0)
			timeout_stop();
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	// Full-word write of one register byte.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, 4'hF, q);
	endtask

	// Read and compare one register.
	task automatic rdchk(input logic [2:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		chk(q, e);
	endtask

	// Value that a reference output should copy from its source.
	function automatic logic srcval(int w, int s, logic pre);
		if (s >= 29)
			return w ? ext_b : ext_a;
		return pre ? pre_ja[s] : post_ja[s];
	endfunction

	// Output must equal its source one cycle earlier, with drive on.
	task automatic follow(input int w, input int s, input logic pre);
		logic v;
		repeat (2) @(negedge sys_clk_in);
		v = srcval(w, s, pre);
		repeat (24)
		begin
			@(negedge sys_clk_in);
			chk(w ? {sec_oe, sec_o} : {pri_oe, pri_o}, {1'b1, v});
			v = srcval(w, s, pre);
		end
		@(posedge sys_clk_in);
	endtask

	// Length of one high or low phase of a free-running output.
	task automatic half(input int w, input longint hz);
		int n, e;
		logic v;
		e = int'(64'h80000000 / ((hz << 32) / 64'd125000000));
		@(negedge sys_clk_in);
		v = w ? e1_o : t1_o;
		n = 0;
		while ((w ? e1_o : t1_o) === v && n < 90000)
		begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 90000)
			timeout_stop();
		v = ~v;
		n = 0;
		while ((w ? e1_o : t1_o) === v && n < 90000)
		begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 90000)
			timeout_stop();
		rng(n, e - 2, e + 2);
	endtask

	// Rising edges of the primary output over 4000 cycles.
	task automatic rises(input longint hz);
		int n, e;
		logic p;
		p = pri_o;
		n = 0;
		repeat (4000)
		begin
			@(negedge sys_clk_in);
			if (pri_o === 1'b1 && p === 1'b0)
				n++;
			p = pri_o;
		end
		e = int'(4000 * hz / 125000000);
		rng(n, e - 1, e + 2);
		@(posedge sys_clk_in);
	endtask

	// Main sequence.
	initial
	begin
		rst_b_in = 1'b0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 3'h0;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hF;
		master_multiplier_straps_in = 4'hB;
		n_mismatch = 0;
		n_checks = 0;
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(negedge sys_clk_in);
		chk({t1_oe, t1_o, e1_oe, e1_o, pri_oe, pri_o, sec_oe, sec_o}, 0);
		@(posedge sys_clk_in);
		rdchk(rco_pkg::IDX_FREE_CTRL, {24'h0, rco_pkg::RST_FREE_CTRL});
		rdchk(rco_pkg::IDX_PRI_SEL, {24'h0, rco_pkg::RST_SEL});
		rdchk(rco_pkg::IDX_SEC_SEL, {24'h0, rco_pkg::RST_SEL});
		rdchk(rco_pkg::IDX_REF_CFG, 32'h10);
		wr(rco_pkg::IDX_STATUS, 8'hFF);
		rdchk(rco_pkg::IDX_STATUS, {26'h0, e1_mode[0], e1_mode[0], 4'hB});
		for (int a = 5; a < 8; a++)
		begin
			wr(3'(a), 8'hFF);
			rdchk(3'(a), 32'h0);
		end
		bus(1'b1, rco_pkg::IDX_FREE_CTRL, 32'hFF, 4'hE, q_drop);
		rdchk(rco_pkg::IDX_FREE_CTRL, 32'h0);
		wr(rco_pkg::IDX_SEC_SEL, 8'hDA);
		rdchk(rco_pkg::IDX_SEC_SEL, 32'hDA);
		// Channel sources through either tap, synthesizer bypassed.
		for (int s = 0; s < 16; s += 5)
		begin
			wr(rco_pkg::IDX_REF_CFG, 8'h50);
			wr(rco_pkg::IDX_PRI_SEL, 8'h40 | 8'(s));
			wr(rco_pkg::IDX_SEC_SEL, 8'h40 | 8'(15 - s));
			follow(0, s, 1'b1);
			follow(1, 15 - s, 1'b1);
			rdchk(rco_pkg::IDX_STATUS, {26'h0, e1_mode[15 - s], e1_mode[s], 4'hB});
			wr(rco_pkg::IDX_REF_CFG, 8'h10);
			follow(0, s, 1'b0);
		end
		// External inputs; rate bit set on the primary, clear on the secondary.
		for (int s = 29; s < 32; s++)
		begin
			wr(rco_pkg::IDX_PRI_SEL, 8'h60 | 8'(s));
			wr(rco_pkg::IDX_SEC_SEL, 8'h40 | 8'(s));
			follow(0, s, 1'b0);
			follow(1, s, 1'b0);
			rdchk(rco_pkg::IDX_STATUS, {26'h0, 2'b01, 4'hB});
		end
		wr(rco_pkg::IDX_SEC_SEL, 8'h3D);
		repeat (3) @(negedge sys_clk_in);
		chk({sec_oe, sec_o}, 0);
		@(posedge sys_clk_in);
		// Bypassed synthesizer ignores the free-run bit.
		wr(rco_pkg::IDX_PRI_SEL, 8'h40);
		wr(rco_pkg::IDX_REF_CFG, 8'h1A);
		follow(0, 0, 1'b0);
		// The slow free rates are timed while the synthesizer codes run,
		// which keeps the whole run short.
		wr(rco_pkg::IDX_FREE_CTRL, 8'h0F);
		fork
			half(0, 1544);
			half(1, 2048);
			// Free run skips codes 0 and 3.
			for (int c = 1; c < 7; c++)
			begin
				if (c != 3)
				begin
					wr(rco_pkg::IDX_REF_CFG, 8'h08 | 8'(c));
					rises(rate[c]);
				end
			end
		join
		@(posedge sys_clk_in);
		// Both free-running outputs at 8 kHz.
		wr(rco_pkg::IDX_FREE_CTRL, 8'h0A);
		@(negedge sys_clk_in);
		chk({t1_oe, e1_oe}, 2'b11);
		fork
			half(0, 8000);
			half(1, 8000);
		join
		report_and_stop();
	end
endmodule
